// ===== design/clvc_defines.vh
// Constants for the camera link video capture front end.
`ifndef CLVC_DEFINES_VH
`define CLVC_DEFINES_VH
// ==========================================================================
// Usage encodings
`define CLVC_FRAME_START_EDGE 2'h0
`define CLVC_FRAME_IGNORED 2'h1
`define CLVC_FRAME_COVER 2'h2
`define CLVC_LINE_START_EDGE 1'h0
`define CLVC_LINE_IGNORED 1'h1
`define CLVC_DATA_UNGATED 1'h0
`define CLVC_DATA_GATED 1'h1
// ==========================================================================
// Control line modes
`define CLVC_CC_GPIO 2'h0
`define CLVC_CC_RESET 2'h1
`define CLVC_CC_EXPOSE 2'h2
// ==========================================================================
// Widths and reset values
`define CLVC_SKIP_W 8
`define CLVC_COUNT_W 16
`define CLVC_DATA_W 24
`define CLVC_CC_PULSE_CYCLES 16'h0064
`endif

// ===== design/clvc_capture.v
// Camera link video capture front end with camera control outputs.
// Function
// - At line-valid rise with line enabled, skip line_lead_skip qualified cycles first.
// - After skip, capture exactly line_active_count words, then end the line.
// - After a complete line, ignore cycles until next line-valid rise.
// - Default configuration does not use data-valid; gating is optional.
// - Leading skip 0 to 255 qualified cycles, default 0; trailing skip unlimited.
// - All cycles qualified when data-valid ignored; else only data-valid high.
// - When gated, no capture on cycles with data-valid low.
// - When gated, leading-skip counter holds while data-valid is low.
// - Frame start edge mode: frame-valid rise starts frame, fall ignored.
// - Frame ignored mode: frame-valid input disregarded entirely.
// - Frame cover mode: record from frame-valid rise until its fall.
// - Line start edge mode: line-valid rise starts line, fall ignored.
// - Line ignored mode: line-valid input disregarded entirely.
// - Gated: capture only data-valid high cycles; ungated: data-valid no effect.
// - Drive four camera control outputs as reset, expose or general purpose.
// - Expose mode: pulse leading edge starts exposure, trailing edge ends it.
// - Frame start edge mode begins a frame only if trigger armed at rise.
// - Frame start edge mode: skip frame_lead_skip lines, capture frame_active_lines, ignore rest of frame.
// - Frame cover with trigger armed: acquire every line until frame-valid falls.
`timescale 1ns/100ps
`default_nettype none
`include "clvc_defines.vh"
module clvc_capture #(
  parameter DATA_W = `CLVC_DATA_W,
  parameter COUNT_W = `CLVC_COUNT_W,
  parameter [15:0] CC_PULSE_CYCLES = `CLVC_CC_PULSE_CYCLES
) (
  input wire clk,
  input wire reset_n,
  input wire link_clk,
  input wire frame_valid,
  input wire line_valid,
  input wire data_valid,
  input wire [DATA_W-1:0] link_data,
  input wire [1:0] frame_valid_usage,
  input wire line_valid_usage,
  input wire data_valid_usage,
  input wire [7:0] line_lead_skip,
  input wire [COUNT_W-1:0] line_active_count,
  input wire [7:0] frame_lead_skip,
  input wire [COUNT_W-1:0] frame_active_lines,
  input wire trigger_arm,
  input wire [7:0] cc_mode,
  input wire [3:0] cc_level,
  input wire [3:0] cc_fire,
  output reg [DATA_W-1:0] pixel_data,
  output reg pixel_valid,
  output reg begin_of_line,
  output reg end_of_line,
  output reg frame_active,
  output reg line_active,
  output reg [3:0] camera_control
);

// ==========================================================================
// Link sampling
// The link clock is sampled by clk; a link edge is found from the last two
// synchronised samples, and all link signals are taken on that edge.
reg [2:0] lclk_s;
reg [DATA_W+2:0] lnk_s1;
reg [DATA_W+2:0] lnk_s2;
wire link_edge = lclk_s[1] & ~lclk_s[2];
always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    lclk_s <= 3'h0;
    lnk_s1 <= {(DATA_W+3){1'b0}};
    lnk_s2 <= {(DATA_W+3){1'b0}};
  end else begin
    lclk_s <= {lclk_s[1:0], link_clk};
    lnk_s1 <= {frame_valid, line_valid, data_valid, link_data};
    lnk_s2 <= lnk_s1;
  end
end

// Values held from the previous link edge, for edge detection.
reg fv_q;
reg lv_q;
reg [DATA_W-1:0] dat_q;
reg fv_d;
reg lv_d;
reg dv_d;
always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    fv_q <= 1'b0;
    lv_q <= 1'b0;
    dat_q <= {DATA_W{1'b0}};
    fv_d <= 1'b0;
    lv_d <= 1'b0;
    dv_d <= 1'b0;
  end else if (link_edge) begin
    fv_q <= lnk_s2[DATA_W+2];
    lv_q <= lnk_s2[DATA_W+1];
    dv_d <= lnk_s2[DATA_W];
    dat_q <= lnk_s2[DATA_W-1:0];
    fv_d <= fv_q;
    lv_d <= lv_q;
  end
end

// ==========================================================================
// Qualification and edges
reg tick;
always @(posedge clk or negedge reset_n) begin
  if (!reset_n)
    tick <= 1'b0;
  else
    tick <= link_edge;
end
wire gated = (data_valid_usage == `CLVC_DATA_GATED);
wire qual = tick & (~gated | dv_d);
wire fv_rise = tick & fv_q & ~fv_d;
wire fv_fall = tick & ~fv_q & fv_d;
wire lv_rise = tick & lv_q & ~lv_d;
wire f_edge = (frame_valid_usage == `CLVC_FRAME_START_EDGE);
wire f_cover = (frame_valid_usage == `CLVC_FRAME_COVER);
wire f_ign = (frame_valid_usage == `CLVC_FRAME_IGNORED);
wire l_ign = (line_valid_usage == `CLVC_LINE_IGNORED);

// ==========================================================================
// Counter helpers
// Both helpers keep the count at its own width, so no carry bit is lost
// or padded silently when a count meets a configuration value.
function [COUNT_W-1:0] cnt_inc;
  input [COUNT_W-1:0] v;
  begin
    cnt_inc = v + {{(COUNT_W-1){1'b0}}, 1'b1};
  end
endfunction

function [COUNT_W-1:0] cnt_last;
  input [COUNT_W-1:0] v;
  begin
    cnt_last = v - {{(COUNT_W-1){1'b0}}, 1'b1};
  end
endfunction

// ==========================================================================
// Frame state
// Frame-valid falling edges only matter in cover mode.
localparam FR_IDLE = 2'h0;
localparam FR_SKIP = 2'h1;
localparam FR_ACT = 2'h2;
localparam FR_DONE = 2'h3;
reg [1:0] fr_state;
reg [1:0] next_fr_state;
reg [7:0] fr_skip;
reg [COUNT_W-1:0] fr_lines;
reg line_done;
always @* begin
  next_fr_state = fr_state;
  case (fr_state)
    FR_IDLE, FR_DONE: begin
      if (fv_rise && trigger_arm && f_edge)
        next_fr_state = (frame_lead_skip == 8'h00) ? FR_ACT : FR_SKIP;
      else if (fv_rise && trigger_arm && f_cover)
        next_fr_state = FR_ACT;
    end
    FR_SKIP: begin
      if (line_done && fr_skip == frame_lead_skip - 8'h01)
        next_fr_state = FR_ACT;
    end
    FR_ACT: begin
      if (f_cover && fv_fall)
        next_fr_state = FR_IDLE;
      else if (f_edge && line_done && fr_lines == cnt_last(frame_active_lines))
        next_fr_state = FR_DONE;
    end
    default: next_fr_state = FR_IDLE;
  endcase
  if (f_ign)
    next_fr_state = FR_ACT;
end
always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    fr_state <= FR_IDLE;
    fr_skip <= 8'h00;
    fr_lines <= {COUNT_W{1'b0}};
  end else begin
    fr_state <= next_fr_state;
    if (next_fr_state != fr_state) begin
      fr_skip <= 8'h00;
      fr_lines <= {COUNT_W{1'b0}};
    end else if (line_done && fr_state == FR_SKIP)
      fr_skip <= fr_skip + 8'h01;
    else if (line_done && fr_state == FR_ACT)
      fr_lines <= cnt_inc(fr_lines);
  end
end

// ==========================================================================
// Line state
localparam LN_IDLE = 2'h0;
localparam LN_SKIP = 2'h1;
localparam LN_ACT = 2'h2;
reg [1:0] ln_state;
reg [1:0] next_ln_state;
reg [7:0] ln_skip;
reg [7:0] next_ln_skip;
reg [COUNT_W-1:0] ln_px;
reg [COUNT_W-1:0] next_ln_px;
reg next_line_done;
reg take_line;
reg in_line;
reg [7:0] cur_skip;
reg [COUNT_W-1:0] cur_px;
// Skipped lines still run the line counter so frame line counts advance.
// A rise while a line is still open is ignored until that line is closed.
wire line_start = lv_rise & ~l_ign & (ln_state == LN_IDLE) &
  (fr_state == FR_SKIP || fr_state == FR_ACT);
wire raw_mode = l_ign & (fr_state == FR_ACT);
// The rise cycle can itself be the first qualified cycle of the line, so the
// counters are taken as zero in that cycle; waiting for the registered
// state would lose the first word of a line with no leading skip.
always @* begin
  next_ln_state = ln_state;
  next_ln_skip = ln_skip;
  next_ln_px = ln_px;
  next_line_done = 1'b0;
  take_line = 1'b0;
  case (ln_state)
    LN_IDLE: in_line = line_start;
    LN_SKIP, LN_ACT: in_line = 1'b1;
    default: begin
      in_line = 1'b0;
      next_ln_state = LN_IDLE;
    end
  endcase
  cur_skip = line_start ? 8'h00 : ln_skip;
  cur_px = line_start ? {COUNT_W{1'b0}} : ln_px;
  if (line_start) begin
    next_ln_state = LN_SKIP;
    next_ln_skip = 8'h00;
    next_ln_px = {COUNT_W{1'b0}};
  end
  if (in_line && qual) begin
    if (cur_skip != line_lead_skip) begin
      next_ln_skip = cur_skip + 8'h01;
    end else begin
      take_line = 1'b1;
      next_ln_state = LN_ACT;
      next_ln_px = cnt_inc(cur_px);
      if (cur_px == cnt_last(line_active_count)) begin
        next_ln_state = LN_IDLE;
        next_line_done = 1'b1;
      end
    end
  end
  // A frame-valid fall in cover mode closes a line that is still open.
  if (f_cover && fv_fall && ln_state != LN_IDLE)
    next_ln_state = LN_IDLE;
end
always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    ln_state <= LN_IDLE;
    ln_skip <= 8'h00;
    ln_px <= {COUNT_W{1'b0}};
    line_done <= 1'b0;
  end else begin
    ln_state <= next_ln_state;
    ln_skip <= next_ln_skip;
    ln_px <= next_ln_px;
    line_done <= next_line_done;
  end
end

// ==========================================================================
// Pixel output
// Words of skipped frame lines run the line counters but are never kept.
wire fr_keep = (fr_state == FR_ACT);
wire take = (qual & raw_mode) | (take_line & fr_keep);
always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    pixel_data <= {DATA_W{1'b0}};
    pixel_valid <= 1'b0;
    begin_of_line <= 1'b0;
    end_of_line <= 1'b0;
    frame_active <= 1'b0;
    line_active <= 1'b0;
  end else begin
    pixel_valid <= take;
    if (take)
      pixel_data <= dat_q;
    begin_of_line <= take_line && fr_keep && cur_px == {COUNT_W{1'b0}} && !raw_mode;
    end_of_line <= take_line && fr_keep && next_line_done && !raw_mode;
    frame_active <= (fr_state == FR_ACT);
    line_active <= (ln_state == LN_ACT);
  end
end

// ==========================================================================
// Camera control lines
// Reset mode emits a fixed-width pulse; expose mode follows cc_level so
// software sets the exposure time by the pulse width.
reg [15:0] cc_cnt [0:3];
reg [3:0] fire_d;
integer i;
always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    camera_control <= 4'h0;
    fire_d <= 4'h0;
    for (i = 0; i < 4; i = i + 1)
      cc_cnt[i] <= 16'h0000;
  end else begin
    fire_d <= cc_fire;
    for (i = 0; i < 4; i = i + 1) begin
      case (cc_mode[2*i +: 2])
        `CLVC_CC_RESET: begin
          if (cc_fire[i] && !fire_d[i])
            cc_cnt[i] <= CC_PULSE_CYCLES;
          else if (cc_cnt[i] != 16'h0000)
            cc_cnt[i] <= cc_cnt[i] - 16'h0001;
          camera_control[i] <= (cc_cnt[i] != 16'h0000);
        end
        `CLVC_CC_EXPOSE: camera_control[i] <= cc_level[i];
        default: camera_control[i] <= cc_level[i];
      endcase
    end
  end
end

endmodule
`default_nettype wire

// ===== tb/clvc_capture_properties.sv
// Assertion checker for the capture front end.
`timescale 1ns/100ps
`default_nettype none
`include "clvc_defines.vh"
module clvc_capture_checker #(
  parameter [15:0] CC_PULSE_CYCLES = 16'h0064
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic data_valid,
  input wire logic data_valid_usage,
  input wire logic [15:0] line_active_count,
  input wire logic [7:0] cc_mode,
  input wire logic [3:0] cc_level,
  input wire logic pixel_valid,
  input wire logic begin_of_line,
  input wire logic end_of_line,
  input wire logic frame_active,
  input wire logic line_active,
  input wire logic [3:0] camera_control
);
  // ========
  // Helpers
  logic [15:0] words;
  logic [15:0] high_run;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      words <= 16'h0;
      high_run <= 16'h0;
    end else begin
      words <= begin_of_line ? 16'h1 : words + {15'h0, pixel_valid};
      high_run <= camera_control[1] ? high_run + 16'h1 : 16'h0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_bol_has_word: assert property (begin_of_line |-> pixel_valid)
    else $error("line start without a word");
  a_line_word_count: assert property (end_of_line |->
    (begin_of_line ? 16'h1 : words + 16'h1) == line_active_count) else $error("line length wrong");
  a_line_closes: assert property (end_of_line |-> ##[0:3] !line_active)
    else $error("line still active after end");
  a_idle_no_word: assert property (!frame_active [*4] |-> !pixel_valid)
    else $error("word outside a frame");
  a_gated_needs_dv: assert property (
    (data_valid_usage == `CLVC_DATA_GATED && !data_valid) [*8] |-> !pixel_valid)
    else $error("word captured without data valid");
  a_gpio_follows: assert property ($past(reset_n, 2) && cc_mode[1:0] == `CLVC_CC_GPIO &&
    $stable(cc_mode) && $stable(cc_level) |=> camera_control[0] == $past(cc_level[0]))
    else $error("general purpose line wrong");
  a_expose_follows: assert property ($past(reset_n, 2) && cc_mode[5:4] == `CLVC_CC_EXPOSE &&
    $stable(cc_mode) && $stable(cc_level) |=> camera_control[2] == $past(cc_level[2]))
    else $error("expose line wrong");
  a_pulse_width: assert property ($fell(camera_control[1]) &&
    cc_mode[3:2] == `CLVC_CC_RESET |-> high_run == CC_PULSE_CYCLES) else $error("pulse width wrong");
  c_raw_word: cover property (pixel_valid && !line_active);
  c_line_end: cover property (end_of_line);
  c_pulse: cover property ($fell(camera_control[1]));
endmodule
bind clvc_capture clvc_capture_checker #(.CC_PULSE_CYCLES(CC_PULSE_CYCLES)) clvc_capture_checker_inst (
  .clk, .reset_n, .data_valid, .data_valid_usage, .line_active_count, .cc_mode, .cc_level,
  .pixel_valid, .begin_of_line, .end_of_line, .frame_active, .line_active, .camera_control);
`default_nettype wire

// ===== tb/clvc_camera_model.sv
// Behavioural camera that sends frames and notes the words the grabber must keep.
`timescale 1ns/100ps
`default_nettype none
module clvc_camera_model (
  output var logic link_clk,
  output var logic frame_valid,
  output var logic line_valid,
  output var logic data_valid,
  output var logic [23:0] link_data
);
  logic [23:0] exp_q[$];
  initial begin
    {link_clk, frame_valid, line_valid, data_valid, link_data} = 28'h0;
  end
  // The link clock only runs inside this task, so each call is one link cycle.
  task automatic tick(input logic f, l, d, input logic [23:0] v, input bit k);
    {frame_valid, line_valid, data_valid, link_data} = {f, l, d, v};
    if (k) exp_q.push_back(v);
    #80 link_clk = 1'b1;
    #80 link_clk = 1'b0;
  endtask
  // ========
  // Frame with line blanking of two cycles; line-valid low between lines.
  task automatic frame(input bit raw, fv, gate, take, input int nl, nw, skip, cnt, fs, fl);
    int q;
    bit d;
    logic [23:0] v;
    tick(fv, 1'b0, 1'b0, 24'h0, 1'b0);
    for (int l = 0; l < nl; l++) begin
      q = 0;
      for (int w = 0; w < nw; w++) begin
        d = (w % 3) != 1;
        v = {8'(l), 16'(w)} ^ 24'h5a5a5a;
        tick(fv, 1'b1, d, v, take && (d || !gate) && (raw ||
          (l >= fs && l < fs + fl && q >= skip && q < skip + cnt)));
        if (d || !gate) q++;
      end
      repeat (2) tick(fv, 1'b0, 1'b1, ~v, raw && take);
    end
    tick(1'b0, 1'b0, 1'b0, 24'h0, 1'b0);
  endtask
endmodule
`default_nettype wire

// ===== tb/clvc_capture_tb_top.sv
// Testbench for the capture front end and its camera control lines.
`timescale 1ns/100ps
`default_nettype none
module clvc_capture_tb_top;
  logic clk, reset_n, line_valid_usage, data_valid_usage, trigger_arm, pixel_valid;
  logic begin_of_line, end_of_line, frame_active, line_active;
  logic [1:0] frame_valid_usage;
  logic [7:0] line_lead_skip, frame_lead_skip, cc_mode;
  logic [15:0] line_active_count, frame_active_lines;
  logic [3:0] cc_level, cc_fire, camera_control;
  logic [23:0] link_data, pixel_data;
  logic link_clk, frame_valid, line_valid, data_valid;
  logic [31:0] lfsr = 32'h2fd6;
  int n_mismatch = 0;
  int num_checks = 0;
  int cnt;
  clvc_camera_model clvc_camera_model_inst (.link_clk, .frame_valid, .line_valid, .data_valid,
    .link_data);
  clvc_capture #(.CC_PULSE_CYCLES(16'h0004)) clvc_capture_inst (.clk, .reset_n, .link_clk,
    .frame_valid, .line_valid, .data_valid, .link_data, .frame_valid_usage, .line_valid_usage,
    .data_valid_usage, .line_lead_skip, .line_active_count, .frame_lead_skip, .frame_active_lines,
    .trigger_arm, .cc_mode, .cc_level, .cc_fire, .pixel_data, .pixel_valid, .begin_of_line,
    .end_of_line, .frame_active, .line_active, .camera_control);
  // ========
  // Checking
  task automatic chk(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic complete_run();
    if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(negedge clk) begin
    if (pixel_valid === 1'b1) begin
      chk({8'h0, pixel_data}, clvc_camera_model_inst.exp_q.size() > 0 ?
        {8'h0, clvc_camera_model_inst.exp_q.pop_front()} : 32'hx);
    end
  end
  // ========
  // Stimulus
  task automatic cfg(input logic [1:0] fu, input logic lu, du, tr, input logic [7:0] ls,
    input logic [15:0] lc, fl);
    @(negedge clk);
    {frame_valid_usage, line_valid_usage, data_valid_usage, trigger_arm} = {fu, lu, du, tr};
    {line_lead_skip, frame_lead_skip, line_active_count, frame_active_lines} = {ls, 8'h1, lc, fl};
  endtask
  task automatic settle();
    repeat (40) @(negedge clk);
    chk(clvc_camera_model_inst.exp_q.size(), 0);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200us;
    n_mismatch++;
    complete_run();
  end
  initial begin
    {reset_n, frame_valid_usage, line_valid_usage, data_valid_usage, trigger_arm} = 5'h0;
    {line_lead_skip, frame_lead_skip, line_active_count, frame_active_lines} = 48'h0;
    {cc_mode, cc_level, cc_fire} = 16'h0;
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    // Qualified lines start with a random leading skip; dv toggles in both usages.
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      cfg(`CLVC_FRAME_START_EDGE, 1'b0, i[0], 1'b1, {6'h0, lfsr[1:0]}, 16'h3, 16'h2);
      clvc_camera_model_inst.frame(0, 1, i[0], 1, 4, 9, line_lead_skip, 3, 1, 2);
      settle();
    end
    cfg(`CLVC_FRAME_START_EDGE, 1'b0, 1'b0, 1'b0, 8'h0, 16'h3, 16'h2);
    clvc_camera_model_inst.frame(0, 1, 0, 0, 2, 5, 0, 3, 0, 2);
    settle();
    cfg(`CLVC_FRAME_IGNORED, 1'b0, 1'b0, 1'b1, 8'h1, 16'h2, 16'h0);
    clvc_camera_model_inst.frame(0, 0, 0, 1, 3, 4, 1, 2, 0, 99);
    settle();
    cfg(`CLVC_FRAME_COVER, 1'b0, 1'b0, 1'b1, 8'h0, 16'h2, 16'h0);
    clvc_camera_model_inst.frame(0, 1, 0, 1, 3, 4, 0, 2, 0, 99);
    settle();
    cfg(`CLVC_FRAME_COVER, `CLVC_LINE_IGNORED, 1'b1, 1'b1, 8'h0, 16'h2, 16'h0);
    clvc_camera_model_inst.frame(1, 1, 1, 1, 2, 5, 0, 0, 0, 0);
    settle();
    @(negedge clk);
    {cc_mode, cc_level} = {8'h24, 4'hd};
    repeat (3) @(negedge clk);
    chk({28'h0, camera_control}, 32'hd);
    cc_fire = 4'h2;
    cnt = 0;
    repeat (12) begin
      @(negedge clk);
      cnt += camera_control[1];
    end
    chk(cnt, 4);
    cc_level = 4'h9;
    repeat (3) @(negedge clk);
    chk({28'h0, camera_control}, 32'h9);
    complete_run();
  end
endmodule
`default_nettype wire
